// ==== shared/rbs_defines.vh ====
`ifndef RBS_DEFINES_VH
`define RBS_DEFINES_VH

// Clock rate and times, each in its own unit.
`define RBS_CLK_HZ          40000000
`define RBS_STRAP_HOLD_MS   2
`define RBS_SAMPLE_MS       1
`define RBS_EE_MAX_MS       100
`define RBS_NOEE_MAX_MS     10
`define RBS_MAX_ATTEMPTS    3

// Register byte offsets.
`define RBS_REG_CTRL        8'h00
`define RBS_REG_STATUS      8'h04
`define RBS_REG_STRAPS      8'h08
`define RBS_REG_FREQ        8'h0C
`define RBS_REG_ELAPSED     8'h10
`define RBS_REG_ADDR        8'h14

// Control and status field positions.
`define RBS_CTRL_RESTART    0
`define RBS_ST_STABLE       0
`define RBS_ST_HALT         1
`define RBS_ST_LATE         2
`define RBS_ST_CAPTURED     3
`define RBS_ST_BUSY         4

// Host port code that selects the two-wire serial slave.
`define RBS_HOST_SERIAL2W   2'h2

// AXI responses.
`define RBS_RESP_OKAY       2'h0
`define RBS_RESP_SLVERR     2'h2

`endif

// ==== verilog/rbs_reset_bootstrap_sequencer.v ====
`include "rbs_defines.vh"
`default_nettype none

// What this block does
// - Straps held 2 ms; sampled inside that.
// - EEPROM load: stable clocks within 100 ms; deadline grows by 100 ms for each retried load.
// - Failed load retried; third failure halts; a register restart clears the count but does not leave halt.
// - No EEPROM: stable clocks within 10 ms.
// - Decode oscillator strap into eight frequencies.
// - Serial address strap forms low address bits.
module rbs_reset_bootstrap_sequencer #(
  parameter CYC_PER_MS = `RBS_CLK_HZ / 1000,
  parameter [3:0] I2C_BASE_ADDR = 4'h5
) (
  // Clock and chip reset pin.
  input  wire        clk,
  input  wire        reset_n,
  // Bootstrap straps.
  input  wire [2:0]  osc_freq_select_straps,
  input  wire [1:0]  host_port_select_straps,
  input  wire [2:0]  i2cAddrStraps,
  input  wire        primary_secondary_select,
  input  wire        telecom_hierarchy_select,
  // Configuration load and clock status.
  input  wire        eepromLoadEnable,
  input  wire        loadDone,
  input  wire        loadError,
  input  wire        pllLocked,
  output reg         loadStart,
  output reg         clocksStable,
  output reg         halted,
  output reg         coreRun,
  output reg  [14:0] oscFreqKhz,
  output reg  [6:0]  ownI2cAddr,
  // AXI4-Lite slave.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [5:0] S_WAIT  = 6'h01;
  localparam [5:0] S_START = 6'h02;
  localparam [5:0] S_BUSY  = 6'h04;
  localparam [5:0] S_LOCK  = 6'h08;
  localparam [5:0] S_RUN   = 6'h10;
  localparam [5:0] S_HALT  = 6'h20;

  localparam [15:0] SAMPLE_MS = `RBS_SAMPLE_MS;
  localparam [15:0] EE_MAX_MS = `RBS_EE_MAX_MS;
  localparam [15:0] NOEE_MS   = `RBS_NOEE_MAX_MS;
  localparam [1:0]  MAX_TRIES = `RBS_MAX_ATTEMPTS;
  localparam [31:0] MS_LAST   = CYC_PER_MS - 1;

  reg  [5:0]  state;
  reg  [5:0]  next_state;
  reg  [31:0] cycCount;
  reg  [15:0] elapsedMs;
  reg  [1:0]  attempts;
  reg         captured;
  reg         lateFlag;
  reg         eeSel;
  reg  [2:0]  capFreq;
  reg  [1:0]  capHost;
  reg  [2:0]  capAddr;
  reg         capRole;
  reg         capHier;
  reg  [15:0] limitMs;
  reg         restartReq;

  wire msTick = (cycCount == MS_LAST);

  // Elapsed time since release; saturates so a stuck load stays late.
  always @(posedge clk) begin
    if (!reset_n) begin
      cycCount  <= 32'h0;
      elapsedMs <= 16'h0;
    end else if (restartReq) begin
      cycCount  <= 32'h0;
      elapsedMs <= 16'h0;
    end else if (msTick) begin
      cycCount <= 32'h0;
      if (elapsedMs != 16'hFFFF) begin
        elapsedMs <= elapsedMs + 16'h1;
      end
    end else begin
      cycCount <= cycCount + 32'h1;
    end
  end

  // Straps are caught once, halfway through the board's hold window.
  always @(posedge clk) begin
    if (!reset_n) begin
      captured <= 1'b0;
      capFreq  <= 3'h0;
      capHost  <= 2'h0;
      capAddr  <= 3'h0;
      capRole  <= 1'b1;
      capHier  <= 1'b0;
      eeSel    <= 1'b0;
    end else if (!captured && elapsedMs >= SAMPLE_MS) begin
      captured <= 1'b1;
      capFreq  <= osc_freq_select_straps;
      capHost  <= host_port_select_straps;
      capAddr  <= i2cAddrStraps;
      capRole  <= primary_secondary_select;
      capHier  <= telecom_hierarchy_select;
      eeSel    <= eepromLoadEnable;
    end
  end

  // Oscillator frequency decode in kHz.
  always @(posedge clk) begin
    if (!reset_n) begin
      oscFreqKhz <= 15'h0;
    end else begin
      case (capFreq)
        3'h0:    oscFreqKhz <= 15'h2710;
        3'h1:    oscFreqKhz <= 15'h3200;
        3'h2:    oscFreqKhz <= 15'h32C8;
        3'h3:    oscFreqKhz <= 15'h4BF0;
        3'h4:    oscFreqKhz <= 15'h4E20;
        3'h5:    oscFreqKhz <= 15'h6000;
        3'h6:    oscFreqKhz <= 15'h61A8;
        default: oscFreqKhz <= 15'h7800;
      endcase
    end
  end

  // Own serial address; zero unless the two-wire port is selected.
  always @(posedge clk) begin
    if (!reset_n) begin
      ownI2cAddr <= 7'h0;
    end else if (capHost == `RBS_HOST_SERIAL2W) begin
      ownI2cAddr <= {I2C_BASE_ADDR, capAddr};
    end else begin
      ownI2cAddr <= 7'h0;
    end
  end

  // Deadline grows by one nominal bound for each retried load.
  always @* begin
    if (!eeSel) begin
      limitMs = NOEE_MS;
    end else if (attempts <= 2'h1) begin
      limitMs = EE_MAX_MS;
    end else if (attempts == 2'h2) begin
      limitMs = EE_MAX_MS + EE_MAX_MS;
    end else begin
      limitMs = EE_MAX_MS + EE_MAX_MS + EE_MAX_MS;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      S_WAIT: begin
        if (captured) begin
          next_state = eeSel ? S_START : S_LOCK;
        end
      end
      S_START: begin
        next_state = S_BUSY;
      end
      S_BUSY: begin
        if (loadError) begin
          next_state = (attempts >= MAX_TRIES) ? S_HALT : S_START;
        end else if (loadDone) begin
          next_state = S_LOCK;
        end
      end
      S_LOCK: begin
        if (pllLocked) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (!pllLocked) begin
          next_state = S_LOCK;
        end
      end
      S_HALT: begin
        next_state = S_HALT;
      end
      default: begin
        next_state = S_WAIT;
      end
    endcase
    if (restartReq && captured && state != S_HALT) begin
      next_state = eeSel ? S_START : S_LOCK;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state        <= S_WAIT;
      attempts     <= 2'h0;
      loadStart    <= 1'b0;
      clocksStable <= 1'b0;
      halted       <= 1'b0;
      coreRun      <= 1'b0;
      lateFlag     <= 1'b0;
    end else begin
      state        <= next_state;
      loadStart    <= (next_state == S_START);
      clocksStable <= (next_state == S_RUN);
      halted       <= (next_state == S_HALT);
      coreRun      <= 1'b1;
      if (restartReq) begin
        attempts <= 2'h0;
        lateFlag <= 1'b0;
      end else if (next_state == S_START) begin
        attempts <= attempts + 2'h1;
      end
      if (!restartReq && state != S_RUN && elapsedMs >= limitMs) begin
        lateFlag <= 1'b1;
      end
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  reg        awHeld;
  reg        wHeld;
  reg  [7:0] awAddr;
  reg  [31:0] wData;
  reg  [3:0] wStrb;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;

  wire doWrite = awHeld && wHeld && !s_axi_bvalid;

  always @(posedge clk) begin
    if (!reset_n) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h0;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RBS_RESP_OKAY;
      restartReq   <= 1'b0;
    end else begin
      restartReq <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr[7:2] == `RBS_REG_CTRL >> 2) begin
          s_axi_bresp <= `RBS_RESP_OKAY;
          restartReq  <= wStrb[0] && wData[`RBS_CTRL_RESTART];
        end else if (awAddr[7:2] <= `RBS_REG_ADDR >> 2) begin
          s_axi_bresp <= `RBS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `RBS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path.
  assign s_axi_arready = !s_axi_rvalid;

  reg [31:0] statusWord;
  always @* begin
    statusWord = 32'h0;
    statusWord[`RBS_ST_STABLE]   = clocksStable;
    statusWord[`RBS_ST_HALT]     = halted;
    statusWord[`RBS_ST_LATE]     = lateFlag;
    statusWord[`RBS_ST_CAPTURED] = captured;
    statusWord[`RBS_ST_BUSY]     = (state == S_START) || (state == S_BUSY);
    statusWord[9:8]              = attempts;
    statusWord[21:16]            = state;
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RBS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RBS_RESP_OKAY;
      if (s_axi_araddr[7:2] == `RBS_REG_CTRL >> 2) begin
        s_axi_rdata <= 32'h0;
      end else if (s_axi_araddr[7:2] == `RBS_REG_STATUS >> 2) begin
        s_axi_rdata <= statusWord;
      end else if (s_axi_araddr[7:2] == `RBS_REG_STRAPS >> 2) begin
        s_axi_rdata <= {21'h0, eeSel, capHier, capRole, capAddr, capHost, capFreq};
      end else if (s_axi_araddr[7:2] == `RBS_REG_FREQ >> 2) begin
        s_axi_rdata <= {17'h0, oscFreqKhz};
      end else if (s_axi_araddr[7:2] == `RBS_REG_ELAPSED >> 2) begin
        s_axi_rdata <= {16'h0, elapsedMs};
      end else if (s_axi_araddr[7:2] == `RBS_REG_ADDR >> 2) begin
        s_axi_rdata <= {25'h0, ownI2cAddr};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `RBS_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rbs_reset_bootstrap_sequencer

`default_nettype wire

// ==== verification/rbs_assertions.sv ====
`default_nettype none
module rbs_assertions #(
  parameter int         CYC_PER_MS    = 40000,
  parameter logic [3:0] I2C_BASE_ADDR = 4'h5
) (
  // Clock, reset and straps.
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [2:0]  osc_freq_select_straps,
  input wire logic [1:0]  host_port_select_straps,
  input wire logic [2:0]  i2cAddrStraps,
  // Sequencer.
  input wire logic        pllLocked,
  input wire logic        loadStart,
  input wire logic        clocksStable,
  input wire logic        halted,
  input wire logic        coreRun,
  input wire logic [14:0] oscFreqKhz,
  input wire logic [6:0]  ownI2cAddr,
  // Read channel.
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FK[8] = '{10000, 12800, 13000, 19440, 20000, 24576, 25000, 30720};
  int since;
  // Cycles since reset release, saturating past the strap window.
  always @(posedge clk) begin
    if (!reset_n) since <= 0;
    else if (since < 3 * CYC_PER_MS) since <= since + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_lock_loss: assert property ($fell(pllLocked) |-> ##[1:2] !clocksStable) else $error("stable kept");
  a_halt_quiet: assert property (halted |-> !clocksStable && !loadStart) else $error("halt active");
  a_start_pulse: assert property (loadStart |=> !loadStart) else $error("long start");
  a_start_late: assert property (loadStart |-> since >= CYC_PER_MS) else $error("early load");
  a_freq_map: assert property (since == 2 * CYC_PER_MS - 1 |->
    oscFreqKhz == 15'(FK[osc_freq_select_straps])) else $error("bad freq");
  a_addr_map: assert property (since == 2 * CYC_PER_MS - 1 |-> ownI2cAddr ==
    (host_port_select_straps == 2'h2 ? {I2C_BASE_ADDR, i2cAddrStraps} : 7'h00)) else $error("bad addr");
  a_core_wake: assert property ($rose(reset_n) |-> !coreRun ##[1:2] coreRun) else $error("core run");
  a_read_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14 |=>
    s_axi_rvalid && s_axi_rresp == 2'h2) else $error("no slave error");
  c_stable: cover property ($rose(clocksStable));
  c_halt: cover property ($rose(halted));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // rbs_assertions
bind rbs_reset_bootstrap_sequencer rbs_assertions #(.CYC_PER_MS(CYC_PER_MS), .I2C_BASE_ADDR(I2C_BASE_ADDR)) u_chk (.*);
`default_nettype wire

// ==== verification/rbs_ee_model.sv ====
`default_nettype none
module rbs_ee_model (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       reset_n,
  // Load handshake.
  input wire logic       loadStart,
  input wire logic [1:0] failCount,
  input wire logic [7:0] loadDelay,
  output var logic       loadDone,
  output var logic       loadError
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  int tries;
  // Each attempt answers loadDelay + 1 cycles after loadStart is sampled; the first failCount attempts fail.
  always @(posedge clk) begin
    loadDone <= 1'h0;
    loadError <= 1'h0;
    if (!reset_n) begin
      left <= 0;
      tries <= 0;
    end else if (loadStart) left <= loadDelay + 1;
    else if (left == 1) begin
      loadError <= tries < failCount;
      loadDone <= tries >= failCount;
      tries <= tries + 1;
      left <= 0;
    end else if (left > 1) left <= left - 1;
  end
endmodule // rbs_ee_model
`default_nettype wire

// ==== verification/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 20;
  localparam int KHZ[8] = '{10000, 12800, 13000, 19440, 20000, 24576, 25000, 30720};
  logic clk = 0, reset_n = 0, pllLocked = 0, eepromLoadEnable = 0, telecom_hierarchy_select = 0;
  logic primary_secondary_select = 1'h1;
  logic [2:0] osc_freq_select_straps = 3'h0, i2cAddrStraps = 3'h0;
  logic [1:0] host_port_select_straps = 2'h0, failCount = 2'h0, s_axi_bresp, s_axi_rresp;
  logic loadDone, loadError, loadStart, clocksStable, halted, coreRun;
  logic [14:0] oscFreqKhz;
  logic [6:0] ownI2cAddr;
  logic [7:0] loadDelay = 8'h05, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int mismatches = 0, n_compared = 0;
  rbs_reset_bootstrap_sequencer #(.CYC_PER_MS(CPM)) u_dut (.*);
  rbs_ee_model u_ee (.*);
  always #12.5 clk = ~clk;
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tmo;
    check("wait", 32'h1, 32'h0);
    report_and_stop;
  endtask
  function automatic logic [6:0] exp_addr(input logic [1:0] h, input logic [2:0] a);
    return (h == 2'h2) ? {4'h5, a} : 7'h00;
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) tmo;
    s_axi_bready <= 0;
    r = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) tmo;
    s_axi_rready <= 0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic run(input logic ee, input logic [1:0] fails);
    logic [8:0] s;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    s = 9'($urandom);
    if (fails == 0) s[5:4] = 2'h2;
    @(posedge clk);
    reset_n <= 0;
    {osc_freq_select_straps, host_port_select_straps, i2cAddrStraps, telecom_hierarchy_select} <= s;
    eepromLoadEnable <= ee;
    failCount <= fails;
    loadDelay <= 8'($urandom_range(60, 1));
    pllLocked <= 1;
    repeat (10) @(posedge clk);
    reset_n <= 1;
    for (n = 0; n < 7000 && clocksStable !== 1 && halted !== 1; n++) @(posedge clk);
    if (n == 7000) tmo;
    if (fails == 3) check("halted", 32'h1, 32'(halted));
    else check("stable in time", 32'h1, 32'(n <= (ee ? (fails + 1) * 100 : 10) * CPM));
    axi_rd(8'h04, d, r);
    check("status", fails == 3 ? 32'h00200002 : 32'h00100001, d & 32'h003F0007);
    axi_rd(8'h08, d, r);
    check("straps", {21'h0, ee, s[0], 1'h1, s[3:1], s[5:4], s[8:6]}, d);
    axi_rd(8'h0C, d, r);
    check("freq reg", 32'(KHZ[s[8:6]]), d);
    axi_rd(8'h14, d, r);
    check("addr reg", 32'(exp_addr(s[5:4], s[3:1])), d);
    repeat (2 * CPM) @(posedge clk);
    {osc_freq_select_straps, host_port_select_straps, i2cAddrStraps, telecom_hierarchy_select} <= ~s;
    pllLocked <= halted;
    repeat (4) @(posedge clk);
    check("freq", 32'(KHZ[s[8:6]]), 32'(oscFreqKhz));
    check("addr", 32'(exp_addr(s[5:4], s[3:1])), 32'(ownI2cAddr));
    check("stable drop", 32'h0, 32'(clocksStable));
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(12595));
    for (int i = 0; i < 5; i++) run(i != 4, 2'(i));
    axi_rd(8'h18, d, r);
    check("bad read resp", 32'h2, {30'h0, r});
    check("bad read data", 32'h0, d);
    axi_wr(8'h08, 32'hFFFFFFFF, r);
    check("ro write resp", 32'h0, {30'h0, r});
    axi_wr(8'h1C, 32'h1, r);
    check("bad write resp", 32'h2, {30'h0, r});
    axi_wr(8'h00, 32'h1, r);
    check("restart resp", 32'h0, {30'h0, r});
    axi_rd(8'h10, d, r);
    check("elapsed after restart", 32'h0, d);
    repeat (11 * CPM) @(posedge clk);
    axi_rd(8'h04, d, r);
    check("late without load", 32'h00080004, d & 32'h003F0007);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
